/* File: hdl/sadc_frame.sv */
/*
 frame sequencer of the converter: runs on the host serial clock, gated by chip select.
 assumes the analog comparator answers each trial bit; system clock side only reports status.
*/
`default_nettype none
module sadc_frame #(
   parameter int unsigned RES = sadc_pkg::RES_BITS
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic comp_high,
   input wire logic [RES-1:0] raw_offset,
   output logic sdo_o,
   output logic sdo_oe,
   output logic sample_hold,
   output logic [RES-1:0] trial_code,
   output logic acq_ready,
   output logic [RES-1:0] result,
   output logic cal_valid
);
   // power-up state: the link side starts here until the first frame is seen
   logic started_reg;
   logic cal_frame_reg;
   logic [5:0] fall_cnt_reg;
   logic [RES-1:0] sar_reg;
   logic [RES-1:0] shift_reg;
   logic [RES-1:0] offset_reg;
   logic [RES-1:0] cal_acc_reg;
   logic sdo_reg;
   logic conv_done_reg;
   logic done_tog_reg;
   logic [RES-1:0] result_hold_reg;
   logic cal_ok_reg;
   sadc_pkg::sadc_state_e state_reg;
   logic cs_q;
   // calibration status is made on sclk, so it passes the same three stages as the pins
   logic cal_ok_q;
   logic done_a_reg;
   logic done_b_reg;
   // wide enough for the whole acquisition count; a narrower counter would wrap it short
   logic [4:0] acq_wait_reg;

   // frame start: chip select high holds the sequence reset, asynchronously to sclk, until it falls
   always_ff @(negedge sclk or posedge cs_n) begin
      if (cs_n) begin
         fall_cnt_reg <= 6'h00;
      end else if (fall_cnt_reg != 6'h3f) begin
         fall_cnt_reg <= fall_cnt_reg + 6'h01;
      end
   end

   // the first frame decides calibration; started bit set on its first fall
   always_ff @(negedge sclk) begin
      if (rst) begin
         started_reg <= 1'b0;
         cal_frame_reg <= 1'b0;
      end else if (!cs_n && fall_cnt_reg == 6'h00) begin
         started_reg <= 1'b1;
         cal_frame_reg <= !started_reg;
      end
   end

   always_comb begin
      if (cs_n) begin
         state_reg = sadc_pkg::SADC_IDLE;
      end else if (cal_frame_reg || !started_reg) begin
         state_reg = sadc_pkg::SADC_CAL;
      end else if (fall_cnt_reg < sadc_pkg::CONV_END_FALLS) begin
         state_reg = sadc_pkg::SADC_CONV;
      end else begin
         state_reg = sadc_pkg::SADC_IDLE;
      end
   end

   // hold is asserted from select fall until the approximation finishes
   // the combinational decode keeps the hold edge tied to the select fall itself
   always_comb begin
      case (state_reg)
         sadc_pkg::SADC_CONV: begin
            sample_hold = 1'b1;
         end
         sadc_pkg::SADC_CAL: begin
            // inputs stay disconnected while the offset is measured
            sample_hold = 1'b1;
         end
         sadc_pkg::SADC_IDLE: begin
            sample_hold = 1'b0;
         end
         default: begin
            // an illegal code isolates the inputs rather than sampling garbage
            sample_hold = 1'b1;
         end
      endcase
   end

   // successive approximation, one decision per serial clock fall from the second to the thirteenth
   always_ff @(negedge sclk) begin
      if (cs_n == 1'b0 && fall_cnt_reg == 6'h00) begin
         sar_reg <= {1'b1, {(RES-1){1'b0}}};
      end else if (fall_cnt_reg >= 6'h01 && fall_cnt_reg <= 6'(RES)) begin
         sar_reg[RES - 32'(fall_cnt_reg)] <= comp_high;
         if (32'(fall_cnt_reg) < RES) begin
            sar_reg[RES - 1 - 32'(fall_cnt_reg)] <= 1'b1;
         end
      end
   end
   assign trial_code = sar_reg;

   // output shifter: bit index k on fall k; zeros first, msb first, low afterwards
   always_ff @(negedge sclk or posedge cs_n) begin
      if (cs_n) begin
         sdo_reg <= 1'b0;
         shift_reg <= '0;
      end else if (fall_cnt_reg == 6'h00 || cal_frame_reg) begin
         sdo_reg <= 1'b0;
      end else if (fall_cnt_reg >= 6'h01 && fall_cnt_reg <= 6'(RES)) begin
         // the bit decided at this fall leaves at once; the register still holds the trial one
         sdo_reg <= comp_high;
      end else begin
         sdo_reg <= 1'b0;
      end
   end
   assign sdo_o = sdo_reg;
   assign sdo_oe = !cs_n;

   // offset calibration: power-up needs 16 falls, running needs falls 17 to 32
   always_ff @(negedge sclk) begin
      if (rst) begin
         offset_reg <= sadc_pkg::OFFSET_RESET;
         cal_acc_reg <= '0;
         cal_ok_reg <= 1'b0;
      end else begin
         if (fall_cnt_reg == 6'h00) begin
            cal_acc_reg <= raw_offset;
         end
         if (cal_frame_reg && fall_cnt_reg == sadc_pkg::PWRUP_CAL_FALLS - 6'h01) begin
            offset_reg <= cal_acc_reg;
            cal_ok_reg <= 1'b1;
         end else if (!cal_frame_reg && fall_cnt_reg == sadc_pkg::RUN_CAL_END - 6'h01) begin
            offset_reg <= cal_acc_reg;
            cal_ok_reg <= 1'b1;
         end
      end
   end

   // conversion end event, offset-corrected result captured on the link side
   always_ff @(negedge sclk) begin
      if (rst) begin
         done_tog_reg <= 1'b0;
         result_hold_reg <= '0;
      end else if (!cal_frame_reg && fall_cnt_reg == 6'(RES)) begin
         done_tog_reg <= !done_tog_reg;
         result_hold_reg <= {sar_reg[RES-1:1], comp_high} - offset_reg;
      end
   end

   // system clock side: toggle crossing, then acquisition interval count
   sadc_sync u_done_sync (
      .clk(clk),
      .rst(rst),
      .din(done_tog_reg),
      .dout(done_a_reg)
   );
   sadc_sync u_cs_sync (
      .clk(clk),
      .rst(rst),
      .din(cs_n),
      .dout(cs_q)
   );
   // the flag only ever rises, so a level crossing needs no handshake
   sadc_sync u_cal_sync (
      .clk(clk),
      .rst(rst),
      .din(cal_ok_reg),
      .dout(cal_ok_q)
   );

   always_ff @(posedge clk) begin
      if (rst) begin
         done_b_reg <= 1'b0;
         result <= '0;
         acq_wait_reg <= 5'h00;
         acq_ready <= 1'b1;
         cal_valid <= 1'b0;
      end else begin
         done_b_reg <= done_a_reg;
         cal_valid <= cal_ok_q;
         if (done_a_reg != done_b_reg) begin
            // the result is stable for a whole frame, so capturing after the toggle is safe
            result <= result_hold_reg;
            acq_wait_reg <= 5'(sadc_pkg::ACQ_CYCLES - 1);
            acq_ready <= 1'b0;
         end else if (acq_wait_reg != 5'h00) begin
            acq_wait_reg <= acq_wait_reg - 5'h01;
         end else if (cs_q) begin
            acq_ready <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

/* File: hdl/sadc_pkg.sv */
/*
 package of constants for the serial converter frame block.
 assumes a host clocks the frame with a chip select and serial clock.
*/
// Notes on behaviour
// - the input is held at the chip select fall and its conversion starts right after.
// - the serial clock steps the approximation and shifts the result; there is no other conversion clock.
// - a conversion lasts twelve serial clock periods plus the select-to-first-fall interval.
// - the sampling stage is isolated while converting and reconnected for acquisition afterwards.
// - at a 32 MHz serial clock the pair sustains two million conversions per second.
// - an offset calibration runs when the host starts one, at power-up or later.
// - each frame after the first sends two zeros then twelve result bits on serial clock falls, then stays low after 14 clocks.
// - a chip select rise ends the frame and releases the data output.
// - the first frame after power-up calibrates with output low and needs 16 falls to update the store.
`default_nettype none
package sadc_pkg;
   localparam int unsigned RES_BITS = 12;
   localparam int unsigned LEAD_ZEROS = 2;
   localparam logic [5:0] FRAME_BITS = 6'h0e;
   localparam logic [5:0] PWRUP_CAL_FALLS = 6'h10;
   localparam logic [5:0] RUN_CAL_START = 6'h11;
   localparam logic [5:0] RUN_CAL_END = 6'h20;
   localparam logic [5:0] CONV_END_FALLS = 6'h0d;
   localparam logic [11:0] OFFSET_RESET = 12'h000;
   localparam int unsigned SYS_CLK_MHZ = 250;
   localparam int unsigned ACQ_NS = 90;
   localparam int unsigned ACQ_CYCLES = (ACQ_NS * SYS_CLK_MHZ + 999) / 1000;
   localparam int unsigned SYNC_STAGES = 3;
   typedef enum logic [2:0] {
      SADC_IDLE = 3'b001,
      SADC_CONV = 3'b010,
      SADC_CAL = 3'b100
   } sadc_state_e;
endpackage
`default_nettype wire

/* File: hdl/sadc_sync.sv */
/*
 three stage level synchroniser; change counted when stages two and three agree.
 assumes the input is asynchronous to clk.
*/
`default_nettype none
module sadc_sync (
   input wire logic clk,
   input wire logic rst,
   input wire logic din,
   output logic dout
);
   logic [2:0] sh_reg;
   always_ff @(posedge clk) begin
      if (rst) begin
         sh_reg <= 3'h0;
         dout <= 1'b0;
      end else begin
         sh_reg <= {sh_reg[1:0], din};
         if (sh_reg[1] == sh_reg[2]) begin
            dout <= sh_reg[2];
         end
      end
   end
endmodule
`default_nettype wire

/* File: verification/sadc_frame_sva.sv */
/* port assertions for the converter frame block.
 assumes sclk is slow enough for clk to see every edge. */
`default_nettype none
module sadc_frame_sva #(parameter int unsigned RES = 12) (
   input wire logic clk,
   input wire logic rst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdo_o,
   input wire logic sdo_oe,
   input wire logic sample_hold,
   input wire logic [RES-1:0] trial_code,
   input wire logic acq_ready,
   input wire logic cal_valid
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic [5:0] nf_reg;
   always_ff @(posedge clk) begin
      if (rst || cs_n) nf_reg <= 6'h00;
      else if ($fell(sclk)) nf_reg <= nf_reg + 6'h01;
   end
   property p_oe; $rose(cs_n) |-> ##[0:1] !sdo_oe; endproperty
   a_oe: assert property (p_oe) else $error("data output not released");
   property p_hs; $fell(cs_n) |-> ##[0:1] sample_hold; endproperty
   a_hs: assert property (p_hs) else $error("sample not held");
   property p_lead; $fell(cs_n) |-> ##[0:1] (sdo_oe && !sdo_o); endproperty
   a_lead: assert property (p_lead) else $error("leading zero missing");
   property p_conv; cal_valid && nf_reg inside {[6'h01:6'h0b]} |-> sample_hold; endproperty
   a_conv: assert property (p_conv) else $error("hold dropped early");
   property p_end; cal_valid && nf_reg == 6'h0d |-> !sample_hold; endproperty
   a_end: assert property (p_end) else $error("no acquisition after conversion");
   property p_step; !$stable(trial_code) && !cs_n && !$past(cs_n) |-> $fell(sclk); endproperty
   a_step: assert property (p_step) else $error("code moved without sclk fall");
   property p_tail; nf_reg >= 6'h0e && sdo_oe |-> !sdo_o; endproperty
   a_tail: assert property (p_tail) else $error("data not low after frame");
   property p_acq; $rose(acq_ready) |-> cs_n && !sample_hold; endproperty
   a_acq: assert property (p_acq) else $error("ready while busy");
   property p_cal; cal_valid |=> cal_valid; endproperty
   a_cal: assert property (p_cal) else $error("calibration flag lost");
   c_cal: cover property ($rose(cal_valid));
   c_run: cover property (nf_reg == 6'h20);
   c_acq: cover property ($rose(acq_ready));
endmodule
bind sadc_frame sadc_frame_sva #(.RES(RES)) i_sva (.clk, .rst, .sclk, .cs_n, .sdo_o, .sdo_oe,
   .sample_hold, .trial_code, .acq_ready, .cal_valid);
`default_nettype wire

/* File: verification/sadc_host.sv */
/* host serial controller model: drives chip select and an 80 ns sclk.
 assumes the caller spaces frames by the ready flag. */
`default_nettype none
module sadc_host (
   output logic cs_n,
   output logic sclk,
   input wire logic sdo_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [13:0] word_reg;
   logic tail_reg;
   // sclk stands high outside frames
   initial begin
      cs_n = 1'b1;
      sclk = 1'b1;
   end
   task automatic pulse();
      sclk = 1'b0;
      #40;
      sclk = 1'b1;
      #40;
   endtask
   // the first bit is sampled 20 ns after the select fall, the rest at the rise, half a period after the launching fall
   task automatic frame(input int falls);
      word_reg = 14'h0000;
      tail_reg = 1'b0;
      // step off the system clock edge so no link edge races it
      #1;
      cs_n = 1'b0;
      #20;
      word_reg[13] = sdo_o;
      for (int i = 1; i <= falls; i++) begin
         sclk = 1'b0;
         #40;
         sclk = 1'b1;
         if (i < 14) word_reg[13-i] = sdo_o;
         else tail_reg = tail_reg | sdo_o;
         #40;
      end
      cs_n = 1'b1;
   endtask
endmodule
`default_nettype wire

/* File: verification/sar_adc_serial_frame_tb.sv */
/* self-checking bench of the converter frame block.
 assumes a comparator that keeps a trial bit while the input is not below it. */
`default_nettype none
module sar_adc_serial_frame_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic comp_high = 1'b0;
   logic [11:0] ain = 12'h000;
   logic sclk, cs_n, sdo_o, sdo_oe, sample_hold, acq_ready, cal_valid;
   logic [11:0] trial_code, result;
   int bad_count = 0;
   int n_checks = 0;
   logic [25:0] rows [4] = '{{12'h000, 14'h0000}, {12'h800, 14'h0800}, {12'hfff, 14'h0fff}, {12'ha5a, 14'h0a5a}};
   always #2 clk = ~clk;
   always @(posedge clk) comp_high <= (ain >= trial_code);
   sadc_frame i_sadc_frame (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .comp_high(comp_high),
      .raw_offset(12'h000), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .sample_hold(sample_hold),
      .trial_code(trial_code), .acq_ready(acq_ready), .result(result), .cal_valid(cal_valid));
   sadc_host i_sadc_host (.cs_n(cs_n), .sclk(sclk), .sdo_o(sdo_o));
   task automatic check(input string what, input logic [13:0] exp, input logic [13:0] got);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wait_acq();
      int i;
      i = 0;
      // acquisition also follows the power-up calibration, which never drops the ready flag
      repeat (sadc_pkg::ACQ_CYCLES) @(posedge clk);
      while (acq_ready !== 1'b1 && i < 100) begin
         @(posedge clk);
         i++;
      end
      if (acq_ready !== 1'b1) begin
         bad_count++;
         $display("[FAIL] acq_ready expected 1 seen %b", acq_ready);
      end
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk);
      i_sadc_host.pulse();
      repeat (18) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      check("idle oe", 14'h0000, {13'h0, sdo_oe});
      i_sadc_host.frame(16);
      check("cal word", 14'h0000, i_sadc_host.word_reg);
      repeat (8) @(posedge clk);
      check("cal flag", 14'h0001, {13'h0, cal_valid});
      $display("test power-up calibration done");
      foreach (rows[k]) begin
         @(posedge clk) ain <= rows[k][25:14];
         wait_acq();
         i_sadc_host.frame(14);
         check("word", rows[k][13:0], i_sadc_host.word_reg);
         check("result", {2'h0, rows[k][25:14]}, {2'h0, result});
      end
      $display("test row frames done");
      @(posedge clk) ain <= 12'h7ff;
      wait_acq();
      i_sadc_host.frame(32);
      check("run word", 14'h07ff, i_sadc_host.word_reg);
      check("run tail", 14'h0000, {13'h0, i_sadc_host.tail_reg});
      repeat (2) @(posedge clk);
      check("released oe", 14'h0000, {13'h0, sdo_oe});
      $display("test running calibration done");
      final_report();
   end
   initial begin
      #40000;
      bad_count++;
      final_report();
   end
endmodule
`default_nettype wire
